/* File: chls_pkg.sv */
// Constants, types and object map for the current-limit homing host controller
// Functional notes
// - Homing requested only from positioning mode
// - Signed target gives direction and travel limit
// - Control nibble xx0x disables voltage, switch-on-disabled
// - Control nibble x110 shutdown, ready to switch on
// - Switch on follows shutdown, switched-on state
// - Control nibble 1111 enables operation
// - Host writes zero target velocity second, after disabling voltage
// - Operating mode value 1 selects positioning
// - Homing method -1 selects current limitation
// - Host picks target beyond the soft stop
// - Switch-on command is control nibble 0111
package chls_pkg;

  // ******************************
  // Register map (AHB byte offsets)
  // ******************************
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STAT      = 8'h04;
  localparam logic [7:0]  REG_PARAM0    = 8'h08;
  localparam int          NUM_PARAM     = 9;
  localparam int          CTRL_START    = 0;
  localparam int          CTRL_ABORT    = 1;
  localparam int          STAT_BUSY     = 0;
  localparam int          STAT_DONE     = 1;
  localparam int          STAT_FAIL     = 2;
  localparam int          STAT_REFUSED  = 3;
  localparam int          STAT_ABORTED  = 4;
  localparam int          STAT_DEVST_LO = 5;
  localparam int          STAT_MODE_LO  = 8;
  localparam int          STAT_STEP_LO  = 16;
  localparam int          STAT_FSM_LO   = 21;
  localparam logic [31:0] METHOD_RESET  = 32'hFFFFFFFF;
  localparam logic [31:0] PARAM_RESET   = 32'h00000000;

  // ******************************
  // Device objects
  // ******************************
  localparam logic [15:0] OBJ_CW_IDX     = 16'h8100;
  localparam logic [7:0]  OBJ_CW_SUB     = 8'h01;
  localparam logic [15:0] OBJ_MODE_IDX   = 16'h8280;
  localparam logic [7:0]  OBJ_MODE_SUB   = 8'h01;
  localparam logic [15:0] OBJ_TVEL_IDX   = 16'h8400;
  localparam logic [7:0]  OBJ_TVEL_SUB   = 8'h03;
  localparam logic [15:0] OBJ_HOME_IDX   = 16'h8300;
  localparam logic [7:0]  OBJ_METHOD_SUB = 8'h02;
  localparam logic [7:0]  OBJ_TARGET_SUB = 8'h05;
  localparam logic [7:0]  OBJ_FASTV_SUB  = 8'h06;
  localparam logic [7:0]  OBJ_SLOWV_SUB  = 8'h07;
  localparam logic [7:0]  OBJ_ACC_SUB    = 8'h08;
  localparam logic [7:0]  OBJ_DEC_SUB    = 8'h09;
  localparam logic [7:0]  OBJ_OFFSET_SUB = 8'h10;
  localparam logic [15:0] OBJ_ILIM_IDX   = 16'h8600;
  localparam logic [7:0]  OBJ_ILIMP_SUB  = 8'h04;
  localparam logic [7:0]  OBJ_ILIMN_SUB  = 8'h05;

  localparam logic [31:0] CW_DISABLE_VOLT = 32'h00000000;
  localparam logic [31:0] CW_SHUTDOWN     = 32'h00000006;
  localparam logic [31:0] CW_SWITCH_ON    = 32'h00000007;
  localparam logic [31:0] CW_ENABLE_OP    = 32'h0000000F;
  localparam logic [31:0] MODE_POSITION   = 32'h00000001;
  localparam logic [31:0] MODE_HOMING     = 32'h00000006;
  localparam logic [31:0] TVEL_ZERO       = 32'h00000000;
  localparam logic [7:0]  DEV_MODE_POS    = 8'h01;

  // Device state codes as reported on the state pins
  localparam logic [2:0]  DST_NONE = 3'h0;
  localparam logic [2:0]  DST_SOD  = 3'h1;
  localparam logic [2:0]  DST_RTSO = 3'h2;
  localparam logic [2:0]  DST_SWON = 3'h3;
  localparam logic [2:0]  DST_OPEN = 3'h4;

  localparam logic [4:0]  STEP_HOMING = 5'h0F;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ISSUE    = 3'b001,
    ST_WAITOBJ  = 3'b010,
    ST_WAITDEV  = 3'b011,
    ST_WAITHOME = 3'b100,
    ST_WAITBACK = 3'b101
  } chls_state_t;

  typedef enum logic [1:0] {
    OM_IDLE = 2'b00,
    OM_REQ  = 2'b01,
    OM_REL  = 2'b10
  } chls_om_state_t;

  typedef struct packed {
    logic [15:0] idx;
    logic [7:0]  sub;
    logic [31:0] data;
    logic [2:0]  waitSt;
  } chls_step_t;

endpackage

/* File: chls_if.sv */
// Interfaces between the controller core, its bus slave and its object writer
`timescale 1ns/1ns
interface chls_reg_if;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slv  (output wr, output addr, output wdata, input rdata);
  modport core (input wr, input addr, input wdata, output rdata);
endinterface

interface chls_obj_if;
  logic        start;
  logic [15:0] idx;
  logic [7:0]  sub;
  logic [31:0] data;
  logic        done;
  modport ctl (output start, output idx, output sub, output data, input done);
  modport mst (input start, input idx, input sub, input data, output done);
endinterface

/* File: chls_ahb_slave.sv */
// AHB-Lite slave front end for the controller registers
`timescale 1ns/1ns
module chls_ahb_slave (
  input  wire logic        clk,
  input  wire logic        rstN,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  chls_reg_if.slv          regs
);

  // ******************************
  // Transfer tracking
  // ******************************
  logic       wrPendQ, wrPendD, rdPendQ, rdPendD, readyQ, readyD;
  logic [7:0] addrQ, addrD;
  logic [31:0] rdataQ, rdataD;
  logic       addrPhase;

  // Only word transfers are expected; size is not checked
  assign addrPhase   = hsel & htrans[1] & hready;
  assign regs.wr    = wrPendQ;
  assign regs.addr  = addrQ;
  assign regs.wdata = hwdata;

  // Reads take one wait state so a write just before is already visible
  always_comb begin
    wrPendD = 1'b0;
    rdPendD = 1'b0;
    readyD  = 1'b1;
    addrD   = addrQ;
    rdataD  = rdataQ;
    if (rdPendQ) begin
      rdataD = regs.rdata;
    end
    if (addrPhase) begin
      addrD   = haddr[7:0];
      wrPendD = hwrite;
      rdPendD = ~hwrite;
      readyD  = hwrite;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPendQ <= 1'b0;
      rdPendQ <= 1'b0;
      readyQ  <= 1'b1;
      addrQ   <= 8'h00;
      rdataQ  <= 32'h00000000;
    end else begin
      wrPendQ <= wrPendD;
      rdPendQ <= rdPendD;
      readyQ  <= readyD;
      addrQ   <= addrD;
      rdataQ  <= rdataD;
    end
  end

  assign hreadyout = readyQ;
  assign hrdata    = rdataQ;
  assign hresp     = 1'b0;

endmodule // chls_ahb_slave

/* File: chls_obj_master.sv */
// Four-phase object writer toward the device parameter port
`timescale 1ns/1ns
module chls_obj_master (
  input  wire logic        clk,
  input  wire logic        rstN,
  chls_obj_if.mst          obj,
  output logic             devReq,
  output logic [15:0]      devIndex,
  output logic [7:0]       devSub,
  output logic [31:0]      devData,
  input  wire logic        devAck
);

  chls_pkg::chls_om_state_t stQ, stD;
  logic        ackS1, ackS2;
  logic        reqQ, reqD, doneQ, doneD;
  logic [15:0] idxQ, idxD;
  logic [7:0]  subQ, subD;
  logic [31:0] dataQ, dataD;

  // Ack comes from the device domain
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ackS1 <= 1'b0;
      ackS2 <= 1'b0;
    end else begin
      ackS1 <= devAck;
      ackS2 <= ackS1;
    end
  end

  always_comb begin
    stD   = stQ;
    reqD  = reqQ;
    doneD = 1'b0;
    idxD  = idxQ;
    subD  = subQ;
    dataD = dataQ;
    unique case (stQ)
      chls_pkg::OM_IDLE: begin
        if (obj.start) begin
          idxD  = obj.idx;
          subD  = obj.sub;
          dataD = obj.data;
          reqD  = 1'b1;
          stD   = chls_pkg::OM_REQ;
        end
      end
      chls_pkg::OM_REQ: begin
        if (ackS2) begin
          reqD = 1'b0;
          stD  = chls_pkg::OM_REL;
        end
      end
      chls_pkg::OM_REL: begin
        // Wait for ack release so the next request is never merged
        if (!ackS2) begin
          doneD = 1'b1;
          stD   = chls_pkg::OM_IDLE;
        end
      end
      default: stD = chls_pkg::OM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stQ   <= chls_pkg::OM_IDLE;
      reqQ  <= 1'b0;
      doneQ <= 1'b0;
      idxQ  <= 16'h0000;
      subQ  <= 8'h00;
      dataQ <= 32'h00000000;
    end else begin
      stQ   <= stD;
      reqQ  <= reqD;
      doneQ <= doneD;
      idxQ  <= idxD;
      subQ  <= subD;
      dataQ <= dataD;
    end
  end

  assign obj.done = doneQ;
  assign devReq   = reqQ;
  assign devIndex = idxQ;
  assign devSub   = subQ;
  assign devData  = dataQ;

endmodule // chls_obj_master

/* File: chls_homing_ctrl.sv */
// Host controller that commissions and runs current-limit homing on the motion device
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module chls_homing_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             devReq,
  output logic [15:0]      devIndex,
  output logic [7:0]       devSub,
  output logic [31:0]      devData,
  input  wire logic        devAck,
  input  wire logic [2:0]  devState,
  input  wire logic [7:0]  devMode,
  input  wire logic        devHomeOk,
  input  wire logic        devHomeFail
);

  // ******************************
  // Reset release
  // ******************************
  logic rstS1, rstN;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstS1 <= 1'b0;
      rstN  <= 1'b0;
    end else begin
      rstS1 <= 1'b1;
      rstN  <= rstS1;
    end
  end

  // ******************************
  // Device status synchronisers
  // ******************************
  // Codes are multi-bit; the device must hold them steady for several clocks
  logic [2:0] stS1, stS2;
  logic [7:0] modeS1, modeS2;
  logic       okS1, okS2, failS1, failS2;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      stS1   <= chls_pkg::DST_NONE;
      stS2   <= chls_pkg::DST_NONE;
      modeS1 <= 8'h00;
      modeS2 <= 8'h00;
      okS1   <= 1'b0;
      okS2   <= 1'b0;
      failS1 <= 1'b0;
      failS2 <= 1'b0;
    end else begin
      stS1   <= devState;
      stS2   <= stS1;
      modeS1 <= devMode;
      modeS2 <= modeS1;
      okS1   <= devHomeOk;
      okS2   <= okS1;
      failS1 <= devHomeFail;
      failS2 <= failS1;
    end
  end

  // ******************************
  // Submodules
  // ******************************
  chls_reg_if regs ();
  chls_obj_if obj ();

  chls_ahb_slave u_ahb (
    .clk       (ref_clk),
    .rstN      (rstN),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .regs      (regs)
  );

  chls_obj_master u_obj (
    .clk      (ref_clk),
    .rstN     (rstN),
    .obj      (obj),
    .devReq   (devReq),
    .devIndex (devIndex),
    .devSub   (devSub),
    .devData  (devData),
    .devAck   (devAck)
  );

  // ******************************
  // Homing parameters
  // ******************************
  // 0 method, 1 limit pos, 2 limit neg, 3 target, 4 fast, 5 slow, 6 acc, 7 dec, 8 offset
  logic [31:0] paramQ [chls_pkg::NUM_PARAM];
  logic [31:0] paramD [chls_pkg::NUM_PARAM];
  logic [5:0]  wrWord;
  logic        startReq, abortReq;

  assign wrWord   = regs.addr[7:2];
  assign startReq = regs.wr && (regs.addr == chls_pkg::REG_CTRL) && regs.wdata[chls_pkg::CTRL_START];
  assign abortReq = regs.wr && (regs.addr == chls_pkg::REG_CTRL) && regs.wdata[chls_pkg::CTRL_ABORT];

  always_comb begin
    for (int i = 0; i < chls_pkg::NUM_PARAM; i++) begin
      paramD[i] = paramQ[i];
      if (regs.wr && (regs.addr[1:0] == 2'b00) &&
          (wrWord == 6'(i + 2))) begin
        paramD[i] = regs.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < chls_pkg::NUM_PARAM; i++) begin
        paramQ[i] <= (i == 0) ? chls_pkg::METHOD_RESET : chls_pkg::PARAM_RESET;
      end
    end else begin
      for (int i = 0; i < chls_pkg::NUM_PARAM; i++) begin
        paramQ[i] <= paramD[i];
      end
    end
  end

  // ******************************
  // Commissioning script
  // ******************************
  chls_pkg::chls_step_t curStep;
  logic [4:0]           stepQ, stepD;

  always_comb begin
    curStep = '{chls_pkg::OBJ_CW_IDX, chls_pkg::OBJ_CW_SUB,
                chls_pkg::CW_DISABLE_VOLT, chls_pkg::DST_SOD};
    unique case (stepQ)
      5'h00: ;
      5'h01: curStep = '{chls_pkg::OBJ_TVEL_IDX, chls_pkg::OBJ_TVEL_SUB,
                         chls_pkg::TVEL_ZERO, chls_pkg::DST_NONE};
      5'h02: curStep = '{chls_pkg::OBJ_MODE_IDX, chls_pkg::OBJ_MODE_SUB,
                         chls_pkg::MODE_POSITION, chls_pkg::DST_NONE};
      5'h03: curStep = '{chls_pkg::OBJ_HOME_IDX, chls_pkg::OBJ_METHOD_SUB,
                         paramQ[0], chls_pkg::DST_NONE};
      5'h04: curStep = '{chls_pkg::OBJ_ILIM_IDX, chls_pkg::OBJ_ILIMP_SUB,
                         paramQ[1], chls_pkg::DST_NONE};
      5'h05: curStep = '{chls_pkg::OBJ_ILIM_IDX, chls_pkg::OBJ_ILIMN_SUB,
                         paramQ[2], chls_pkg::DST_NONE};
      5'h06: curStep = '{chls_pkg::OBJ_HOME_IDX, chls_pkg::OBJ_TARGET_SUB,
                         paramQ[3], chls_pkg::DST_NONE};
      5'h07: curStep = '{chls_pkg::OBJ_HOME_IDX, chls_pkg::OBJ_FASTV_SUB,
                         paramQ[4], chls_pkg::DST_NONE};
      5'h08: curStep = '{chls_pkg::OBJ_HOME_IDX, chls_pkg::OBJ_SLOWV_SUB,
                         paramQ[5], chls_pkg::DST_NONE};
      5'h09: curStep = '{chls_pkg::OBJ_HOME_IDX, chls_pkg::OBJ_ACC_SUB,
                         paramQ[6], chls_pkg::DST_NONE};
      5'h0A: curStep = '{chls_pkg::OBJ_HOME_IDX, chls_pkg::OBJ_DEC_SUB,
                         paramQ[7], chls_pkg::DST_NONE};
      5'h0B: curStep = '{chls_pkg::OBJ_HOME_IDX, chls_pkg::OBJ_OFFSET_SUB,
                         paramQ[8], chls_pkg::DST_NONE};
      5'h0C: curStep = '{chls_pkg::OBJ_CW_IDX, chls_pkg::OBJ_CW_SUB,
                         chls_pkg::CW_SHUTDOWN, chls_pkg::DST_RTSO};
      5'h0D: curStep = '{chls_pkg::OBJ_CW_IDX, chls_pkg::OBJ_CW_SUB,
                         chls_pkg::CW_SWITCH_ON, chls_pkg::DST_SWON};
      5'h0E: curStep = '{chls_pkg::OBJ_CW_IDX, chls_pkg::OBJ_CW_SUB,
                         chls_pkg::CW_ENABLE_OP, chls_pkg::DST_OPEN};
      5'h0F: curStep = '{chls_pkg::OBJ_MODE_IDX, chls_pkg::OBJ_MODE_SUB,
                         chls_pkg::MODE_HOMING, chls_pkg::DST_NONE};
      default: ;
    endcase
  end

  // ******************************
  // Sequencer
  // ******************************
  chls_pkg::chls_state_t stateQ, stateD;
  logic doneQ, doneD, failQ, failD, refQ, refD, abtQ, abtD, objStart;

  assign obj.start = objStart;
  assign obj.idx   = curStep.idx;
  assign obj.sub   = curStep.sub;
  assign obj.data  = curStep.data;

  always_comb begin
    stateD   = stateQ;
    stepD    = stepQ;
    doneD    = doneQ;
    failD    = failQ;
    refD     = refQ;
    abtD     = abtQ;
    objStart = 1'b0;
    unique case (stateQ)
      chls_pkg::ST_IDLE: begin
        if (startReq) begin
          doneD  = 1'b0;
          failD  = 1'b0;
          refD   = 1'b0;
          abtD   = 1'b0;
          stepD  = 5'h00;
          stateD = chls_pkg::ST_ISSUE;
        end
      end
      chls_pkg::ST_ISSUE: begin
        // Homing is only legal while the device still shows positioning mode
        if ((stepQ == chls_pkg::STEP_HOMING) && (modeS2 != chls_pkg::DEV_MODE_POS)) begin
          refD   = 1'b1;
          stateD = chls_pkg::ST_IDLE;
        end else begin
          objStart = 1'b1;
          stateD   = chls_pkg::ST_WAITOBJ;
        end
      end
      chls_pkg::ST_WAITOBJ: begin
        if (obj.done) begin
          if (stepQ == chls_pkg::STEP_HOMING) begin
            stateD = chls_pkg::ST_WAITHOME;
          end else if (curStep.waitSt != chls_pkg::DST_NONE) begin
            stateD = chls_pkg::ST_WAITDEV;
          end else begin
            stepD  = stepQ + 5'h01;
            stateD = chls_pkg::ST_ISSUE;
          end
        end
      end
      chls_pkg::ST_WAITDEV: begin
        if (abortReq) begin
          abtD   = 1'b1;
          stateD = chls_pkg::ST_IDLE;
        end else if (stS2 == curStep.waitSt) begin
          stepD  = stepQ + 5'h01;
          stateD = chls_pkg::ST_ISSUE;
        end
      end
      chls_pkg::ST_WAITHOME: begin
        if (abortReq) begin
          abtD   = 1'b1;
          stateD = chls_pkg::ST_IDLE;
        end else if (failS2) begin
          failD  = 1'b1;
          stateD = chls_pkg::ST_WAITBACK;
        end else if (okS2) begin
          doneD  = 1'b1;
          stateD = chls_pkg::ST_WAITBACK;
        end
      end
      chls_pkg::ST_WAITBACK: begin
        if (abortReq) begin
          abtD   = 1'b1;
          stateD = chls_pkg::ST_IDLE;
        end else if (modeS2 == chls_pkg::DEV_MODE_POS) begin
          stateD = chls_pkg::ST_IDLE;
        end
      end
      default: stateD = chls_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      stateQ <= chls_pkg::ST_IDLE;
      stepQ  <= 5'h00;
      doneQ  <= 1'b0;
      failQ  <= 1'b0;
      refQ   <= 1'b0;
      abtQ   <= 1'b0;
    end else begin
      stateQ <= stateD;
      stepQ  <= stepD;
      doneQ  <= doneD;
      failQ  <= failD;
      refQ   <= refD;
      abtQ   <= abtD;
    end
  end

  // ******************************
  // Register read
  // ******************************
  always_comb begin
    regs.rdata = 32'h00000000;
    if (regs.addr == chls_pkg::REG_STAT) begin
      regs.rdata[chls_pkg::STAT_BUSY]    = (stateQ != chls_pkg::ST_IDLE);
      regs.rdata[chls_pkg::STAT_DONE]    = doneQ;
      regs.rdata[chls_pkg::STAT_FAIL]    = failQ;
      regs.rdata[chls_pkg::STAT_REFUSED] = refQ;
      regs.rdata[chls_pkg::STAT_ABORTED] = abtQ;
      regs.rdata[chls_pkg::STAT_DEVST_LO +: 3] = stS2;
      regs.rdata[chls_pkg::STAT_MODE_LO +: 8]  = modeS2;
      regs.rdata[chls_pkg::STAT_STEP_LO +: 5]  = stepQ;
      regs.rdata[chls_pkg::STAT_FSM_LO +: 3]   = stateQ;
    end else begin
      for (int i = 0; i < chls_pkg::NUM_PARAM; i++) begin
        if ((regs.addr[1:0] == 2'b00) && (regs.addr[7:2] == 6'(i + 2))) begin
          regs.rdata = paramQ[i];
        end
      end
    end
  end

endmodule // chls_homing_ctrl

/* File: chls_homing_ctrl_props.sv */
// Port checker for the homing controller
`timescale 1ns/1ns
module chls_homing_ctrl_props (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        devReq,
  input wire logic [15:0] devIndex,
  input wire logic [31:0] devData,
  input wire logic        devAck,
  input wire logic [2:0]  devState
);
  // ****************
  // Properties
  // ****************
  logic rdTake;
  logic reqUp;
  assign rdTake = hsel && htrans[1] && hready && !hwrite;
  assign reqUp = devReq && !devAck;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_rd_wait; rdTake |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_req_hold; reqUp |=> devReq; endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before ack");
  property p_req_stable; devReq && $past(devReq) |-> $stable({devIndex, devData}); endproperty
  a_req_stable: assert property (p_req_stable) else $error("object changed under request");
  property p_ack_drop; $rose(devAck) |-> ##[2:5] !devReq; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request not released after ack");
  property p_new_req; $rose(devReq) |-> !devAck && !$past(devAck); endproperty
  a_new_req: assert property (p_new_req) else $error("request overlaps old ack");
  property p_cw_code;
    $rose(devReq) && devIndex == 16'h8100 |-> devData inside {32'h0, 32'h6, 32'h7, 32'hF};
  endproperty
  a_cw_code: assert property (p_cw_code) else $error("bad control word");
  property p_mode_code; $rose(devReq) && devIndex == 16'h8280 |-> devData inside {32'h1, 32'h6};
  endproperty
  a_mode_code: assert property (p_mode_code) else $error("bad mode value");
  property p_home_open;
    $rose(devReq) && devIndex == 16'h8280 && devData == 32'h6 |-> devState == 3'h4;
  endproperty
  a_home_open: assert property (p_home_open) else $error("homing not from enabled");
endmodule // chls_homing_ctrl_props

bind chls_homing_ctrl chls_homing_ctrl_props u_props (.ref_clk(ref_clk), .nrst(nrst),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .devReq(devReq), .devIndex(devIndex), .devData(devData), .devAck(devAck),
  .devState(devState));

/* File: chls_dev_model.sv */
// Behavioural motion device on the object port
`timescale 1ns/1ns
module chls_dev_model (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        devReq,
  input  wire logic [15:0] devIndex,
  input  wire logic [31:0] devData,
  input  wire logic [3:0]  ackDly,
  input  wire logic [1:0]  homeRes,
  input  wire logic        noPos,
  output logic             devAck,
  output logic [2:0]       devState,
  output logic [7:0]       devMode,
  output logic             devHomeOk,
  output logic             devHomeFail
);
  logic [3:0] cnt;
  logic [7:0] hcnt;
  logic       homing;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      devAck <= 1'b0;
      devState <= 3'h0;
      devMode <= 8'h0;
      cnt <= 4'h0;
      homing <= 1'b0;
    end else begin
      if (!devReq) begin
        devAck <= 1'b0;
        cnt <= 4'h0;
      end else if (!devAck && cnt != ackDly) begin
        cnt <= cnt + 4'h1;
      end else if (!devAck) begin
        devAck <= 1'b1;
        if (devIndex == 16'h8100) begin
          casez (devData[3:0])
            4'b??0?: devState <= 3'h1;
            4'b?110: devState <= 3'h2;
            4'b0111: devState <= 3'h3;
            4'b1111: devState <= 3'h4;
            default: ;
          endcase
        end
        if (devIndex == 16'h8280 && devData == 32'h1 && !noPos) devMode <= 8'h1;
        if (devIndex == 16'h8280 && devData == 32'h6 && devState == 3'h4 && devMode == 8'h1) begin
          homing <= 1'b1;
          devMode <= 8'h6;
          devHomeOk <= 1'b0;
          devHomeFail <= 1'b0;
          hcnt <= 8'h0;
        end
      end
      // Disabling voltage stops a search that was left hanging
      if (devIndex == 16'h8100 && devAck && !devData[1]) homing <= 1'b0;
      if (homing && homeRes != 2'h2) begin
        hcnt <= hcnt + 8'h1;
        if (hcnt == 8'h14) begin
          homing <= 1'b0;
          devHomeOk <= !homeRes[0];
          devHomeFail <= homeRes[0];
          devMode <= 8'h1;
        end
      end
    end
  end
endmodule // chls_dev_model

/* File: chls_homing_ctrl_tb.sv */
// Self-checking bench for the homing controller
`timescale 1ns/1ns
module chls_homing_ctrl_tb;
  // ****************
  // Bench
  // ****************
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, devData, rd;
  logic [15:0] devIndex;
  logic [7:0]  devSub, devMode;
  logic [2:0]  devState;
  logic        hready, hresp, devReq, devAck, devHomeOk, devHomeFail;
  logic        reqD = 1'b0;
  logic [3:0]  ackDly = 4'h1;
  logic [1:0]  homeRes = 2'h0;
  logic        noPos = 1'b0;
  logic [55:0] wlog[$];
  logic [31:0] pv [9] = '{32'hFFFFFFFF, 32'h120, 32'hF0, 32'h10000, 32'h500, 32'h80,
                          32'h30, 32'h40, 32'h25};
  int          error_cnt = 0;
  int          checks_done = 0;
  initial forever #2 ref_clk = ~ref_clk;
  chls_homing_ctrl dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .devReq(devReq), .devIndex(devIndex),
    .devSub(devSub), .devData(devData), .devAck(devAck), .devState(devState),
    .devMode(devMode), .devHomeOk(devHomeOk), .devHomeFail(devHomeFail));
  chls_dev_model dev (.ref_clk(ref_clk), .nrst(nrst), .devReq(devReq), .devIndex(devIndex),
    .devData(devData), .ackDly(ackDly), .homeRes(homeRes), .noPos(noPos), .devAck(devAck),
    .devState(devState), .devMode(devMode), .devHomeOk(devHomeOk), .devHomeFail(devHomeFail));
  always @(posedge ref_clk) begin
    reqD <= devReq;
    if (devReq && !reqD) wlog.push_back({devIndex, devSub, devData});
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  // Address phase held until hready, then data phase held until hready again
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_idle;
    int n = 0;
    repeat (4) @(posedge ref_clk);
    do begin
      ahb(1'b0, 8'h04, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
  endtask
  task run(input logic [31:0] tgt, input logic [4:0] fl, input logic [7:0] md);
    ahb(1'b1, 8'h14, tgt);
    ahb(1'b1, 8'h00, 32'h1);
    wait_idle;
    chk({27'h0, rd[4:0]}, {27'h0, fl}, "status flags");
    chk({21'h0, rd[15:5]}, {21'h0, md, 3'h4}, "device state and mode");
  endtask
  task t_reset;
    ahb(1'b0, 8'h04, 32'h0);
    chk({16'h0, rd[15:0]}, 32'h0, "status at reset");
    for (int i = 0; i < 9; i++) begin
      ahb(1'b0, 8'h08 + 8'(4 * i), 32'h0);
      chk(rd, (i == 0) ? 32'hFFFFFFFF : 32'h0, "parameter reset");
    end
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk({31'h0, hresp}, 32'h0, "response code");
  endtask
  task t_home_ok;
    logic [23:0] ea [16];
    logic [31:0] ed [16];
    ea = '{24'h810001, 24'h840003, 24'h828001, 24'h830002, 24'h860004, 24'h860005, 24'h830005,
           24'h830006, 24'h830007, 24'h830008, 24'h830009, 24'h830010, 24'h810001, 24'h810001,
           24'h810001, 24'h828001};
    ed = '{32'h0, 32'h0, 32'h1, pv[0], pv[1], pv[2], pv[3], pv[4], pv[5], pv[6], pv[7], pv[8],
           32'h6, 32'h7, 32'hF, 32'h6};
    for (int i = 0; i < 9; i++) ahb(1'b1, 8'h08 + 8'(4 * i), pv[i]);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, pv[6], "parameter readback");
    wlog.delete();
    run(pv[3], 5'h02, 8'h1);
    chk(32'(wlog.size()), 32'd16, "object count");
    for (int i = 0; i < 16; i++) begin
      chk({8'h0, wlog[i][55:32]}, {8'h0, ea[i]}, "object address");
      chk(wlog[i][31:0], ed[i], "object value");
    end
  endtask
  task t_home_fail;
    ackDly <= 4'h7;
    homeRes <= 2'h1;
    run(32'hFFFF0000, 5'h04, 8'h1);
  endtask
  task automatic t_abort;
    int n = 0;
    ackDly <= 4'h2;
    homeRes <= 2'h2;
    ahb(1'b1, 8'h00, 32'h1);
    while (devMode !== 8'h6 && n++ < 2000) @(posedge ref_clk);
    // Mode flips at the ack; the controller only reaches the homing wait after the handshake
    repeat (16) @(posedge ref_clk);
    ahb(1'b1, 8'h00, 32'h2);
    wait_idle;
    chk({27'h0, rd[4:0]}, 32'h10, "abort flags");
  endtask
  task t_refused;
    noPos <= 1'b1;
    homeRes <= 2'h0;
    wlog.delete();
    run(pv[3], 5'h08, 8'h6);
    chk(wlog[$][31:0], 32'hF, "no homing request");
  endtask
  task give_verdict;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset;
    t_home_ok;
    t_home_fail;
    t_abort;
    t_refused;
    give_verdict;
  end
  // Whole run needs about a thousand cycles, so this only catches a hang
  initial begin
    #200000;
    error_cnt++;
    give_verdict;
  end
endmodule // chls_homing_ctrl_tb
